// ---- hw/i2c_bcast_controller.sv ----
// controller end: drives broadcast, start-byte and bus-clear sequences
`timescale 1ns/1ps
`include "i2c_bcast_map.svh"
module i2c_bcast_controller
    import i2c_bcast_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    i2c_bcast_if.controller bus,
    input wire logic reqValid,
    output logic reqReady,
    input wire i2c_bcast_pkg::op_e reqOp,
    input wire i2c_bcast_pkg::addr_t reqAddr,
    input wire i2c_bcast_pkg::byte_t reqData,
    output logic doneValid,
    output logic ackSeen,
    output logic sdaFreed
);
    import i2c_bcast_pkg::*;

    typedef enum {C_IDLE, C_START, C_BIT, C_RESTART, C_STOP, C_CLEAR} cstate_e;

    logic sdaMeta, sdaSync;
    cstate_e state;
    logic [15:0] timer;
    logic phase;
    logic [3:0] bitCnt;
    logic [1:0] byteNo;
    byte_t cur;
    op_e op;
    addr_t addr;
    byte_t data;
    logic sclLow, sdaLow, anyAck;
    logic [3:0] pulses;

    wire tick = (timer == 16'(`BC_CLK_HALF_CYC - 1));
    wire isStartOp = (op == OP_START_BYTE);
    // the 00h code is never sent as a broadcast command
    wire byte_t cmdWord = {data[7:1], 1'b0};
    wire byte_t cmdByte = (cmdWord == `BC_CMD_FORBIDDEN) ? `BC_CMD_LOAD : cmdWord;
    wire byte_t hwByte = {addr, 1'b1};
    wire byte_t nextByte = (byteNo == 2'd0) ? ((op == OP_WRITE) ? {addr, 1'b0} : `BC_ADDR_BYTE)
                         : ((op == OP_BCAST_HWID) ? hwByte
                         : (op == OP_BCAST_CMD) ? cmdByte : data);
    wire byte_t nextByteB = (op == OP_BCAST_HWID) ? hwByte
                          : (op == OP_BCAST_CMD) ? cmdByte : data;

    assign reqReady = (state == C_IDLE);
    assign bus.sclCtrlOe = sclLow;
    assign bus.sdaCtrlOe = sdaLow;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sdaMeta <= 1'b1;
            sdaSync <= 1'b1;
        end else begin
            sdaMeta <= bus.sda;
            sdaSync <= sdaMeta;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= C_IDLE;
            timer <= 16'h0000;
            phase <= 1'b0;
            bitCnt <= 4'h0;
            byteNo <= 2'd0;
            cur <= 8'h00;
            op <= OP_WRITE;
            addr <= 7'h00;
            data <= 8'h00;
            sclLow <= 1'b0;
            sdaLow <= 1'b0;
            anyAck <= 1'b0;
            pulses <= 4'h0;
            doneValid <= 1'b0;
            ackSeen <= 1'b0;
            sdaFreed <= 1'b0;
        end else begin
            doneValid <= 1'b0;
            timer <= tick ? 16'h0000 : timer + 16'h0001;
            if (state == C_IDLE) begin
                timer <= 16'h0000;
                if (reqValid) begin
                    op <= reqOp;
                    addr <= reqAddr;
                    data <= reqData;
                    byteNo <= 2'd0;
                    anyAck <= 1'b0;
                    pulses <= 4'h0;
                    state <= (reqOp == OP_BUS_CLEAR) ? C_CLEAR : C_START;
                    phase <= 1'b0;
                end
            end else if (tick) begin
                case (state)
                    C_START: begin
                        // start, or start byte first when slow pollers are served
                        sdaLow <= 1'b1;
                        state <= C_BIT;
                        bitCnt <= 4'h0;
                        phase <= 1'b0;
                        cur <= isStartOp ? `BC_START_BYTE : nextByte;
                    end
                    C_BIT: begin
                        phase <= !phase;
                        if (!phase) begin
                            sclLow <= 1'b1;
                            sdaLow <= (bitCnt < 4'd8) ? !cur[7] : 1'b0;
                        end else begin
                            sclLow <= 1'b0;
                            if (bitCnt < 4'd8) begin
                                cur <= {cur[6:0], 1'b0};
                                bitCnt <= bitCnt + 4'h1;
                            end else begin
                                if (!sdaSync && !isStartOp) begin
                                    anyAck <= 1'b1;
                                end
                                // ack pulse after start byte, then a restart
                                if (isStartOp) begin
                                    state <= C_RESTART;
                                end else if (byteNo == 2'd1 || sdaSync) begin
                                    state <= C_STOP;
                                end else begin
                                    byteNo <= byteNo + 2'd1;
                                    cur <= (byteNo == 2'd0) ? nextByteB : data;
                                    bitCnt <= 4'h0;
                                end
                            end
                        end
                    end
                    C_RESTART: begin
                        phase <= !phase;
                        if (!phase) begin
                            sclLow <= 1'b1;
                            sdaLow <= 1'b0;
                        end else begin
                            sclLow <= 1'b0;
                            op <= OP_WRITE;
                            state <= C_START;
                        end
                    end
                    C_STOP: begin
                        phase <= !phase;
                        if (!phase) begin
                            sclLow <= 1'b1;
                            sdaLow <= 1'b1;
                        end else begin
                            sclLow <= 1'b0;
                            state <= C_CLEAR;
                            pulses <= 4'd15;
                        end
                    end
                    C_CLEAR: begin
                        // nine pulses while data is held low, then stop
                        phase <= !phase;
                        if (pulses == 4'd15) begin
                            // stop; the line is judged a half bit later, once we let go
                            sdaLow <= 1'b0;
                            pulses <= 4'd14;
                        end else if (pulses == 4'd14) begin
                            state <= C_IDLE;
                            doneValid <= 1'b1;
                            ackSeen <= anyAck;
                            sdaFreed <= sdaSync;
                        end else if (!phase) begin
                            sclLow <= 1'b1;
                            sdaLow <= 1'b0;
                        end else begin
                            sclLow <= 1'b0;
                            if (sdaSync || pulses == 4'(`BC_RECOVER_PULSES - 1)) begin
                                state <= C_STOP;
                            end else begin
                                pulses <= pulses + 4'h1;
                            end
                        end
                    end
                    default: state <= C_IDLE;
                endcase
            end
        end
    end

endmodule

// ---- hw/i2c_bcast_map.svh ----
// timing, address and command constants for the broadcast-handling two-wire link
`ifndef I2C_BCAST_MAP_SVH
`define I2C_BCAST_MAP_SVH
`define BC_ADDR_BYTE 8'h00
`define BC_START_BYTE 8'h01
`define BC_CMD_RESET_LOAD 8'h06
`define BC_CMD_LOAD 8'h04
`define BC_CMD_FORBIDDEN 8'h00
`define BC_CLK_HALF_NS 2000
`define BC_CLK_PERIOD_NS 20
`define BC_CLK_HALF_CYC ((`BC_CLK_HALF_NS + `BC_CLK_PERIOD_NS - 1) / `BC_CLK_PERIOD_NS)
`define BC_RECOVER_PULSES 9
`endif

// ---- hw/i2c_bcast_pkg.sv ----
// types shared by both ends of the broadcast-handling link
package i2c_bcast_pkg;
    typedef logic [6:0] addr_t;
    typedef logic [7:0] byte_t;
    typedef enum logic [2:0] {
        OP_WRITE,
        OP_BCAST_CMD,
        OP_BCAST_HWID,
        OP_START_BYTE,
        OP_BUS_CLEAR
    } op_e;
endpackage

// ---- hw/i2c_bcast_if.sv ----
// two-wire bus carrier: open-drain lines resolved from the enables of both ends and of an external source
`timescale 1ns/1ps
interface i2c_bcast_if;
    logic sclCtrlOe;
    logic sdaCtrlOe;
    logic sclTgtOe;
    logic sdaTgtOe;
    logic sclExtOe;
    logic sdaExtOe;
    logic scl;
    logic sda;
    assign scl = !(sclCtrlOe || sclTgtOe || sclExtOe);
    assign sda = !(sdaCtrlOe || sdaTgtOe || sdaExtOe);
    modport target (input scl, input sda, output sclTgtOe, output sdaTgtOe);
    modport controller (input scl, input sda, output sclCtrlOe, output sdaCtrlOe);
endinterface

// ---- hw/i2c_bcast_target.sv ----
// target end: address match, broadcast command decode, start-byte handling
`timescale 1ns/1ps
`include "i2c_bcast_map.svh"

// Summary of operation
// - ignore broadcast when broadcast disabled, no acknowledge
// - acknowledge broadcast, then receive following bytes
// - acknowledge processable bytes, refuse the rest
// - second byte bit zero selects command form
// - code 06h resets then latches address pins
// - code 04h latches address pins, no reset
// - controller never sends 00h second byte
// - other command codes cause no action
// - identification form carries seven-bit controller address
// - answer as target at announced controller address; this target only records it in hwCtrlAddr
// - reset command optional; broadcast is zero write
// - come up as receiving target, take destination
// - controller sends start byte, ack pulse, restart
// - never acknowledge the start byte
// - restart after start byte resets bus logic
// - slow pollers may sample start byte zeros
// - controller issues nine pulses on stuck data
// - release data within nine recovery pulses
// - stuck clock recovered by hardware reset
// - any start resets bus logic, expect address
module i2c_bcast_target
    import i2c_bcast_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    i2c_bcast_if.target bus,
    input wire i2c_bcast_pkg::addr_t addrPins,
    input wire logic bcastEnable,
    input wire logic swResetEnable,
    output i2c_bcast_pkg::addr_t ownAddr,
    output i2c_bcast_pkg::addr_t destAddr,
    output logic destValid,
    output i2c_bcast_pkg::addr_t hwCtrlAddr,
    output logic hwCtrlSeen,
    output i2c_bcast_pkg::byte_t rxData,
    output logic rxValid,
    output logic swResetPulse
);
    import i2c_bcast_pkg::*;

    typedef enum {ST_IDLE, ST_ADDR, ST_ACK, ST_DATA, ST_IGNORE} tstate_e;

    logic sclMeta, sclSync, sclPrev, sdaMeta, sdaSync, sdaPrev;
    tstate_e state;
    logic [3:0] bitCnt;
    byte_t shift;
    logic ackDrive;
    logic isBcast;
    logic [1:0] byteIdx;
    logic fromHw;
    logic configured;
    logic doResetHold;
    addr_t strapMeta, strapSync;
    logic [1:0] cfgMeta, cfgSync;

    wire bcastOn = cfgSync[0];
    wire swResetOn = cfgSync[1];
    wire sclRise = sclSync && !sclPrev;
    wire sclFall = !sclSync && sclPrev;
    wire startCond = sclSync && sclPrev && sdaPrev && !sdaSync;
    wire stopCond = sclSync && sclPrev && !sdaPrev && sdaSync;
    wire byte_t rxByte = {shift[6:0], sdaSync};
    wire isBcastAddr = (rxByte == `BC_ADDR_BYTE);
    wire isOwnAddr = (rxByte[7:1] == ownAddr) && !rxByte[0];
    wire isCmdReset = (rxByte == `BC_CMD_RESET_LOAD);
    wire isCmdLoad = (rxByte == `BC_CMD_LOAD);
    wire isHwForm = rxByte[0];
    // second broadcast byte: only defined codes or the hw form are taken
    wire canProcess2nd = isHwForm || isCmdLoad || (isCmdReset && swResetOn);
    wire canProcessAddr = (isBcastAddr && bcastOn) || isOwnAddr;
    wire doReset = isBcast && byteIdx == 2'd1 && isCmdReset && swResetOn;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclMeta <= 1'b1;
            sclSync <= 1'b1;
            sclPrev <= 1'b1;
            sdaMeta <= 1'b1;
            sdaSync <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclMeta <= bus.scl;
            sclSync <= sclMeta;
            sclPrev <= sclSync;
            sdaMeta <= bus.sda;
            sdaSync <= sdaMeta;
            sdaPrev <= sdaSync;
        end
    end

    // straps and enables are quasi-static; no reset, so they have
    // settled by the time reset is released
    always_ff @(posedge clk) begin
        strapMeta <= addrPins;
        strapSync <= strapMeta;
        cfgMeta <= {swResetEnable, bcastEnable};
        cfgSync <= cfgMeta;
    end

    // strap capture happens clocked, never inside the async reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            configured <= 1'b0;
            ownAddr <= 7'h00;
        end else if (!configured) begin
            configured <= 1'b1;
            ownAddr <= strapSync;
        end else if (sclRise && state == ST_DATA && bitCnt == 4'd7 && isBcast
                     && byteIdx == 2'd1 && (isCmdLoad || doReset)) begin
            ownAddr <= strapSync;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            bitCnt <= 4'h0;
            shift <= 8'h00;
            ackDrive <= 1'b0;
            isBcast <= 1'b0;
            byteIdx <= 2'd0;
            fromHw <= 1'b0;
            rxData <= 8'h00;
            rxValid <= 1'b0;
            swResetPulse <= 1'b0;
            destAddr <= 7'h00;
            destValid <= 1'b0;
            hwCtrlAddr <= 7'h00;
            hwCtrlSeen <= 1'b0;
        end else begin
            rxValid <= 1'b0;
            swResetPulse <= 1'b0;
            if (startCond) begin
                // covers restart after the start byte too
                state <= ST_ADDR;
                bitCnt <= 4'h0;
                ackDrive <= 1'b0;
                isBcast <= 1'b0;
                byteIdx <= 2'd0;
            end else if (stopCond) begin
                state <= ST_IDLE;
                ackDrive <= 1'b0;
            end else if (sclRise && (state == ST_ADDR || state == ST_DATA)) begin
                shift <= rxByte;
                bitCnt <= bitCnt + 4'h1;
                if (bitCnt == 4'd7) begin
                    state <= ST_ACK;
                    if (state == ST_ADDR) begin
                        // start byte 01h never matches, so no acknowledge
                        ackDrive <= canProcessAddr;
                        isBcast <= isBcastAddr;
                        if (!canProcessAddr) begin
                            state <= ST_IGNORE;
                        end
                    end else if (isBcast && byteIdx == 2'd1) begin
                        ackDrive <= canProcess2nd;
                        fromHw <= isHwForm;
                        if (isHwForm) begin
                            hwCtrlAddr <= rxByte[7:1];
                            hwCtrlSeen <= 1'b1;
                        end
                        if (doReset) begin
                            swResetPulse <= 1'b1;
                            destValid <= 1'b0;
                            hwCtrlSeen <= 1'b0;
                        end
                    end else begin
                        ackDrive <= !isBcast || fromHw;
                        rxData <= rxByte;
                        rxValid <= 1'b1;
                        if (!isBcast) begin
                            destAddr <= rxByte[7:1];
                            destValid <= 1'b1;
                        end
                    end
                end
            end else if (sclFall && state == ST_ACK) begin
                if (bitCnt == 4'd8) begin
                    bitCnt <= 4'd9;
                end else begin
                    ackDrive <= 1'b0;
                    bitCnt <= 4'h0;
                    byteIdx <= (byteIdx == 2'd3) ? 2'd3 : byteIdx + 2'd1;
                    state <= (ackDrive && !doResetHold) ? ST_DATA : ST_IGNORE;
                end
            end
        end
    end

    // after a reset command the target drops back off the transfer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            doResetHold <= 1'b0;
        end else if (startCond) begin
            doResetHold <= 1'b0;
        end else if (swResetPulse) begin
            doResetHold <= 1'b1;
        end
    end

    // ack only for the one bit slot; released in every other state
    assign bus.sdaTgtOe = ackDrive && state == ST_ACK && bitCnt == 4'd9;
    assign bus.sclTgtOe = 1'b0;
endmodule

// ---- verification/i2c_bcast_sva.sv ----
// concurrent checks on the shared two-wire lines between both ends
`timescale 1ns/1ps
module i2c_bcast_sva (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda,
    input wire logic sclCtrlOe,
    input wire logic sdaCtrlOe,
    input wire logic sclTgtOe,
    input wire logic sdaTgtOe,
    input wire logic sclExtOe,
    input wire logic sdaExtOe
);
    logic sclQ;
    logic sdaQ;
    logic [3:0] bitCnt;
    wire startSeen = sclQ && scl && sdaQ && !sda;
    wire sclRise = scl && !sclQ;
    wire [3:0] next_bitCnt = (bitCnt == 4'h8) ? 4'h0 : bitCnt + 4'h1;
    // bit slot count, 8 during the ack low half and 0 while the ack is clocked
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclQ <= 1'b1;
            sdaQ <= 1'b1;
            bitCnt <= 4'h0;
        end else begin
            sclQ <= scl;
            sdaQ <= sda;
            if (startSeen)
                bitCnt <= 4'h0;
            else if (sclRise)
                bitCnt <= next_bitCnt;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    tgt_scl_free_a: assert property (!sclTgtOe)
        else $error("target pulled the clock line");
    ack_slot_only_a: assert property (sdaTgtOe |-> (bitCnt == 4'h8 || bitCnt == 4'h0))
        else $error("target drove data outside the ack slot");
    ack_high_stable_a: assert property ((scl && sclQ) |-> $stable(sdaTgtOe))
        else $error("target changed data while clock high");
    ack_low_rise_a: assert property ($rose(sdaTgtOe) |-> !scl)
        else $error("target ack began with clock high");
    ack_release_a: assert property ($rose(sdaTgtOe) |-> ##[1:300] !sdaTgtOe)
        else $error("target held data low too long");
    reset_release_a: assert property ($rose(rst_n) |-> !sdaTgtOe && !sdaCtrlOe && !sclCtrlOe)
        else $error("line driven right after reset");
    scl_low_half_a: assert property ($rose(sclCtrlOe) |=> sclCtrlOe[*8] ##[1:200] !sclCtrlOe)
        else $error("clock low half out of range");
    scl_high_half_a: assert property ($fell(sclCtrlOe) |=> !sclCtrlOe[*8])
        else $error("clock high half too short");
endmodule

// ---- verification/i2c_target_broadcast_handling_tb.sv ----
// self-checking bench joining controller and target across the shared bus
`timescale 1ns/1ps
module i2c_target_broadcast_handling_tb;
    import i2c_bcast_pkg::*;
    logic clk;
    logic rst_n;
    logic bcastEnable;
    logic swResetEnable;
    logic reqValid;
    logic reqReady, doneValid, ackSeen, sdaFreed, destValid, hwCtrlSeen, rxValid, swResetPulse;
    op_e reqOp;
    addr_t addrPins, reqAddr, ownAddr, destAddr, hwCtrlAddr, expOwn;
    byte_t reqData, rxData;
    logic expDv;
    logic sclPrev = 1'b1;
    int err_total = 0;
    int n_tests = 0;
    int rxCount = 0;
    int rstCount = 0;
    int pulseCnt = 0;
    int releaseAt = 0;
    logic stuck = 1'b0;
    i2c_bcast_if bus();
    i2c_bcast_target i_i2c_bcast_target (.clk(clk), .rst_n(rst_n), .bus(bus),
        .addrPins(addrPins), .bcastEnable(bcastEnable), .swResetEnable(swResetEnable),
        .ownAddr(ownAddr), .destAddr(destAddr), .destValid(destValid),
        .hwCtrlAddr(hwCtrlAddr), .hwCtrlSeen(hwCtrlSeen), .rxData(rxData),
        .rxValid(rxValid), .swResetPulse(swResetPulse));
    i2c_bcast_controller i_i2c_bcast_controller (.clk(clk), .rst_n(rst_n), .bus(bus),
        .reqValid(reqValid), .reqReady(reqReady), .reqOp(reqOp), .reqAddr(reqAddr),
        .reqData(reqData), .doneValid(doneValid), .ackSeen(ackSeen), .sdaFreed(sdaFreed));
    i2c_bcast_sva i_i2c_bcast_sva (.clk(clk), .rst_n(rst_n), .scl(bus.scl), .sda(bus.sda),
        .sclCtrlOe(bus.sclCtrlOe), .sdaCtrlOe(bus.sdaCtrlOe), .sclTgtOe(bus.sclTgtOe),
        .sdaTgtOe(bus.sdaTgtOe), .sclExtOe(bus.sclExtOe), .sdaExtOe(bus.sdaExtOe));
    always @(posedge clk) begin
        if (rxValid === 1'b1)
            rxCount <= rxCount + 1;
        if (swResetPulse === 1'b1)
            rstCount <= rstCount + 1;
    end
    // stuck-low injector lets go of data after a chosen clock pulse
    assign bus.sclExtOe = 1'b0;
    assign bus.sdaExtOe = stuck && (releaseAt == 0 || pulseCnt < releaseAt);
    always @(negedge clk) begin
        sclPrev <= bus.scl;
        if (!stuck)
            pulseCnt <= 0;
        else if (bus.scl === 1'b1 && sclPrev === 1'b0)
            pulseCnt <= pulseCnt + 1;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk1(input string name, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic chk7(input string name, input addr_t exp, input addr_t got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk8(input string name, input byte_t exp, input byte_t got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chkN(input string name, input int exp, input int got);
        n_tests++;
        if (got != exp) begin
            err_total++;
            $display("ERROR %s expected %0d seen %0d", name, exp, got);
        end
    endtask
    task automatic doOp(input op_e op, input addr_t a, input byte_t d);
        int i;
        @(negedge clk);
        reqOp = op;
        reqAddr = a;
        reqData = d;
        reqValid = 1'b1;
        chk1("reqReady", 1'b1, reqReady);
        @(negedge clk);
        reqValid = 1'b0;
        for (i = 0; i < 20000 && doneValid !== 1'b1; i++)
            @(negedge clk);
        if (i == 20000) begin
            chk1("doneValid", 1'b1, 1'b0);
            print_verdict();
        end
    endtask
    // bit 0 is cleared and a zero code turns into the address-load code on the wire
    function automatic byte_t wireCode(input byte_t d);
        return ((d & 8'hFE) == 8'h00) ? 8'h04 : (d & 8'hFE);
    endfunction
    task automatic bc(input byte_t d);
        byte_t c;
        int r0;
        logic rstHit;
        logic loadHit;
        c = wireCode(d);
        rstHit = bcastEnable && swResetEnable && c == 8'h06;
        loadHit = bcastEnable && (c == 8'h04 || rstHit);
        addrPins = 7'h40 | 7'($urandom);
        r0 = rstCount;
        doOp(OP_BCAST_CMD, 7'h00, d);
        if (loadHit)
            expOwn = addrPins;
        if (rstHit)
            expDv = 1'b0;
        chk1("ackSeen", bcastEnable, ackSeen);
        chk7("ownAddr", expOwn, ownAddr);
        chkN("resets", rstHit ? 1 : 0, rstCount - r0);
        chk1("destValid", expDv, destValid);
        $display("broadcast code %h done", d);
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        static byte_t codes[5] = '{8'h04, 8'h00, 8'h06, 8'h02, 8'h48};
        int i;
        int r0;
        addr_t a;
        byte_t d;
        rst_n = 1'b0;
        reqValid = 1'b0;
        reqOp = OP_WRITE;
        reqAddr = 7'h00;
        reqData = 8'h00;
        bcastEnable = 1'b0;
        swResetEnable = 1'b0;
        i = $urandom(32'hBC29B322);
        addrPins = 7'h40 | 7'($urandom);
        expOwn = addrPins;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        chk7("ownAddr", expOwn, ownAddr);
        for (i = 0; i < 4; i++) begin
            a = i[0] ? expOwn : (expOwn ^ 7'h01);
            d = (i == 3) ? 8'hFF : 8'($urandom);
            r0 = rxCount;
            doOp(OP_WRITE, a, d);
            chk1("ackSeen", i[0], ackSeen);
            chkN("rxCount", i[0] ? 1 : 0, rxCount - r0);
            if (i[0]) begin
                chk8("rxData", d, rxData);
                chk7("destAddr", d[7:1], destAddr);
                chk1("destValid", 1'b1, destValid);
            end
        end
        expDv = 1'b1;
        $display("writes done");
        bc(8'h04);
        bcastEnable = 1'b1;
        for (i = 0; i < 5; i++)
            bc(codes[i]);
        swResetEnable = 1'b1;
        bc(8'h06);
        a = 7'($urandom) | 7'h01;
        doOp(OP_BCAST_HWID, a, 8'h00);
        chk1("hwCtrlSeen", 1'b1, hwCtrlSeen);
        chk7("hwCtrlAddr", a, hwCtrlAddr);
        $display("identification done");
        d = 8'($urandom);
        r0 = rxCount;
        doOp(OP_START_BYTE, expOwn, d);
        chk1("ackSeen", 1'b1, ackSeen);
        chk8("rxData", d, rxData);
        chkN("rxCount", 1, rxCount - r0);
        doOp(OP_START_BYTE, expOwn ^ 7'h01, d);
        chk1("ackSeen", 1'b0, ackSeen);
        $display("start byte done");
        for (i = 0; i < 2; i++) begin
            releaseAt = i ? 0 : 4;
            stuck = 1'b1;
            doOp(OP_BUS_CLEAR, 7'h00, 8'h00);
            chk1("sdaFreed", !i[0], sdaFreed);
            // nine pulses, plus the rise that opens the closing stop
            chk1("pulses", 1'b1, i ? pulseCnt == 10 : pulseCnt >= 4 && pulseCnt <= 9);
            stuck = 1'b0;
            @(negedge clk);
        end
        $display("bus clear done");
        reqOp = OP_WRITE;
        reqAddr = expOwn;
        reqValid = 1'b1;
        @(negedge clk);
        reqValid = 1'b0;
        repeat (1500) @(negedge clk);
        rst_n = 1'b0;
        @(negedge clk);
        chk1("sda", 1'b1, bus.sda);
        chk1("scl", 1'b1, bus.scl);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        doOp(OP_WRITE, addrPins, 8'h5A);
        chk1("ackSeen", 1'b1, ackSeen);
        $display("mid-frame reset done");
        print_verdict();
    end
endmodule
